// >>> i2c_status_address_clock.v
// Function
// - Start-sent set on start, SR1-then-DR write clears
// - Ack failure set on NACK, SR2 read clears
// - Ack failure alone never holds clock
// - Slave stop after ack sets stop-seen
// - Arbitration loss sets flag, no stretch
// - Arbitration loss drops to slave mode
// - No arbitration during master-receive acknowledge
// - Misplaced start/stop sets bus error
// - Master should stop or restart after error
// - General call flag set, cleared by stop
// - Status-two upper three bits read zero
// - Fast/standard bit survives disable
// - Clock divider sets rate, survives disable
// - Buffer write starts transmission
// - Receive next byte only after buffer read
// - Seven-bit match ignores direction bit
// - Address 01h never answered
// - Ten-bit own address survives disable
// - Disable clears control/status except stop
`include "i2c_consts.vh"
module i2c_status_address_clock (
  input  wire       i_mclk,
  input  wire       i_rst_b,
  input  wire [7:0] i_addr,
  input  wire [7:0] i_wdata,
  input  wire       i_wr,
  input  wire       i_rd,
  output reg  [7:0] o_rdata,
  input  wire       i_scl,
  input  wire       i_sda,
  output reg        o_scl_oe,
  output reg        o_scl_o,
  output reg        o_sda_oe,
  output reg        o_sda_o,
  output reg        o_irq
);
  // ****************************************
  // Reset release and pin synchronisers
  // ****************************************
  reg [1:0] rst_reg;
  wire      rst_b = rst_reg[1];
  always @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b)
      rst_reg <= 2'h0;
    else
      rst_reg <= {rst_reg[0], 1'b1};
  end
  wire scl_s;
  wire sda_s;
  i2c_sync3 u_scl (.i_mclk(i_mclk), .i_rst_b(rst_b), .i_d(i_scl), .o_q(scl_s));
  i2c_sync3 u_sda (.i_mclk(i_mclk), .i_rst_b(rst_b), .i_d(i_sda), .o_q(sda_s));

  // ****************************************
  // Registers
  // ****************************************
  reg [7:0] cr_reg;
  reg [7:0] ccr_reg;
  reg [7:0] oar1_reg;
  reg [7:0] oar2_reg;
  reg [7:0] dr_reg;
  reg       start_sent_flag;
  reg       ack_failure_flag;
  reg       stop_seen_flag;
  reg       arbitration_lost_flag;
  reg       bus_error_flag;
  reg       general_call_seen_flag;
  reg       byte_done_flag;
  reg       addr_match_flag;
  reg       hdr10_flag;
  reg       master_slave_bit;
  reg       tra_bit;
  reg       busy_bit;
  reg       sr1_seen_reg;
  reg       sr2_seen_reg;
  reg       dr_full_reg;
  wire block_on             = cr_reg[`CR_ON];
  wire gen_call_enable      = cr_reg[`CR_GC];
  wire interrupt_enable_bit = cr_reg[`CR_ITE];
  wire fast_mode_select     = ccr_reg[7];
  wire [6:0] clock_divider  = ccr_reg[6:0];
  wire [1:0] timing_band    = oar2_reg[7:6];
  wire evf = start_sent_flag | ack_failure_flag | stop_seen_flag |
             arbitration_lost_flag | bus_error_flag | byte_done_flag |
             addr_match_flag | hdr10_flag;
  wire [7:0] status_one = {evf, hdr10_flag, tra_bit, busy_bit, byte_done_flag,
                           addr_match_flag, master_slave_bit, start_sent_flag};
  wire [7:0] status_two = {3'h0, ack_failure_flag, stop_seen_flag,
                           arbitration_lost_flag, bus_error_flag,
                           general_call_seen_flag};
  wire wr_cr  = i_wr && i_addr == `A_CR;
  wire rd_sr1 = i_rd && i_addr == `A_SR1;
  wire rd_sr2 = i_rd && i_addr == `A_SR2;
  wire wr_dr  = i_wr && i_addr == `A_DR;
  wire rd_dr  = i_rd && i_addr == `A_DR;

  // ****************************************
  // Bus condition detection
  // ****************************************
  reg  scl_d;
  reg  sda_d;
  wire start_det = scl_s && scl_d && sda_d && !sda_s;
  wire stop_det  = scl_s && scl_d && !sda_d && sda_s;
  wire scl_rise  = scl_s && !scl_d;
  wire scl_fall  = !scl_s && scl_d;

  // ****************************************
  // Byte engine
  // ****************************************
  localparam [6:0] S_IDLE  = 7'h01;
  localparam [6:0] S_START = 7'h02;
  localparam [6:0] S_BITS  = 7'h04;
  localparam [6:0] S_ACK   = 7'h08;
  localparam [6:0] S_HOLD  = 7'h10;
  localparam [6:0] S_STOP  = 7'h20;
  localparam [6:0] S_LOST  = 7'h40;
  reg [6:0] st_reg;
  reg [7:0] sh_reg;
  reg [3:0] bit_reg;
  reg [1:0] ph_reg;
  reg       addr_phase_reg;
  reg       hdr_pend_reg;
  reg       lost_now;
  reg       slv_ack_reg;
  wire      tick;
  wire      m_run = block_on && master_slave_bit;
  i2c_clkdiv u_div (
    .i_mclk (i_mclk),
    .i_rst_b(rst_b),
    .i_run  (m_run),
    .i_fast (fast_mode_select),
    .i_div  (clock_divider),
    .o_tick (tick)
  );

  // Seven-bit match ignores bit 0 of own address; 01h never matches
  function addr_hit;
    input [7:0] rx;
    input [7:0] own;
    begin
      addr_hit = (rx[7:1] == own[7:1]) && (rx != `IGN_ADDR);
    end
  endfunction
  wire gc_hit  = gen_call_enable && sh_reg[7:1] == `GC_ADDR && sh_reg != `IGN_ADDR;
  wire h10_hit = sh_reg[7:3] == `HDR10 && sh_reg[2:1] == oar2_reg[2:1];

  // Flag low hold comes only from start-sent, byte-done or address match; master S_HOLD also drives clock low
  wire hold_scl = start_sent_flag | byte_done_flag | addr_match_flag;
  wire drv_en   = block_on;

  always @(posedge i_mclk or negedge rst_b) begin
    if (!rst_b) begin
      cr_reg <= `ZERO8;
      ccr_reg <= `ZERO8;
      oar1_reg <= `ZERO8;
      oar2_reg <= `OAR2_RST;
      dr_reg <= `ZERO8;
      start_sent_flag <= 1'b0;
      ack_failure_flag <= 1'b0;
      stop_seen_flag <= 1'b0;
      arbitration_lost_flag <= 1'b0;
      bus_error_flag <= 1'b0;
      general_call_seen_flag <= 1'b0;
      byte_done_flag <= 1'b0;
      addr_match_flag <= 1'b0;
      hdr10_flag <= 1'b0;
      master_slave_bit <= 1'b0;
      tra_bit <= 1'b0;
      busy_bit <= 1'b0;
      sr1_seen_reg <= 1'b0;
      sr2_seen_reg <= 1'b0;
      dr_full_reg <= 1'b0;
      st_reg <= S_IDLE;
      sh_reg <= `ZERO8;
      bit_reg <= 4'h0;
      ph_reg <= 2'h0;
      addr_phase_reg <= 1'b0;
      hdr_pend_reg <= 1'b0;
      lost_now <= 1'b0;
      slv_ack_reg <= 1'b0;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      o_rdata <= `ZERO8;
      o_scl_oe <= 1'b0;
      o_scl_o <= 1'b0;
      o_sda_oe <= 1'b0;
      o_sda_o <= 1'b0;
      o_irq <= 1'b0;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
      lost_now <= 1'b0;
      // Register reads, data one cycle later
      o_rdata <= `ZERO8;
      if (i_rd) begin
        if (i_addr == `A_CR)
          o_rdata <= cr_reg;
        else if (i_addr == `A_SR1)
          o_rdata <= status_one;
        else if (i_addr == `A_SR2)
          o_rdata <= status_two;
        else if (i_addr == `A_CCR)
          o_rdata <= ccr_reg;
        else if (i_addr == `A_OAR1)
          o_rdata <= oar1_reg;
        else if (i_addr == `A_OAR2)
          o_rdata <= oar2_reg;
        else if (i_addr == `A_DR)
          o_rdata <= dr_reg;
      end
      // Register writes
      if (wr_cr) begin
        if (!block_on) begin
          cr_reg <= {2'h0, i_wdata[`CR_ON], 3'h0, cr_reg[`CR_STOP], 1'b0};
        end else begin
          cr_reg <= {2'h0, i_wdata[5:0]};
          if (i_wdata[`CR_START] && !master_slave_bit && !busy_bit) begin
            master_slave_bit <= 1'b1;
            st_reg <= S_START;
            ph_reg <= 2'h0;
          end
        end
      end
      if (i_wr && i_addr == `A_CCR)
        ccr_reg <= i_wdata;
      if (i_wr && i_addr == `A_OAR1)
        oar1_reg <= i_wdata;
      if (i_wr && i_addr == `A_OAR2) begin
        if (!block_on)
          oar2_reg <= {i_wdata[7:6], 3'h0, i_wdata[2:1], 1'b0};
        else
          oar2_reg <= {timing_band, 3'h0, i_wdata[2:1], 1'b0};
      end
      // Read-then-access sequence tracking
      if (rd_sr1)
        sr1_seen_reg <= 1'b1;
      else if (wr_dr || rd_dr)
        sr1_seen_reg <= 1'b0;
      if (rd_sr1)
        addr_match_flag <= 1'b0;
      if (i_rd && i_addr == `A_SR2)
        sr2_seen_reg <= 1'b1;
      else if (wr_dr)
        sr2_seen_reg <= 1'b0;
      if (rd_sr2) begin
        ack_failure_flag <= 1'b0;
        stop_seen_flag <= 1'b0;
        arbitration_lost_flag <= 1'b0;
        bus_error_flag <= 1'b0;
      end
      if (wr_dr) begin
        dr_reg <= i_wdata;
        dr_full_reg <= 1'b1;
        if (sr1_seen_reg && start_sent_flag) begin
          start_sent_flag <= 1'b0;
          addr_phase_reg <= 1'b1;
          hdr_pend_reg <= i_wdata[7:3] == `HDR10;
        end
        if (sr2_seen_reg && hdr10_flag)
          hdr10_flag <= 1'b0;
        if (sr1_seen_reg)
          byte_done_flag <= 1'b0;
      end
      if (rd_dr) begin
        dr_full_reg <= 1'b0;
        if (sr1_seen_reg)
          byte_done_flag <= 1'b0;
      end

      // Bus state tracking
      if (start_det)
        busy_bit <= 1'b1;
      if (stop_det) begin
        busy_bit <= 1'b0;
        general_call_seen_flag <= 1'b0;
        master_slave_bit <= 1'b0;
        tra_bit <= 1'b0;
        addr_phase_reg <= 1'b0;
        slv_ack_reg <= 1'b0;
        if (!master_slave_bit && addr_phase_reg && cr_reg[`CR_ACK])
          stop_seen_flag <= 1'b1;
      end
      // Misplaced start or stop while a byte is moving, as master or as slave
      if ((start_det || stop_det) &&
          ((st_reg == S_BITS && bit_reg != 4'h0) ||
           (!master_slave_bit && busy_bit && bit_reg != 4'h0 && bit_reg <= 4'h8))) begin
        bus_error_flag <= 1'b1;
        busy_bit <= 1'b0;
        st_reg <= S_IDLE;
      end

      // Master byte engine, quarter-period ticks
      if (m_run && tick) begin
        ph_reg <= ph_reg + 2'h1;
        case (st_reg)
          S_START: begin
            if (ph_reg == 2'h0)
              o_sda_o <= 1'b1;
            else if (ph_reg == 2'h2)
              o_sda_o <= 1'b0;
            else if (ph_reg == 2'h3) begin
              o_scl_o <= 1'b0;
              start_sent_flag <= 1'b1;
              cr_reg[`CR_START] <= 1'b0;
              st_reg <= S_HOLD;
            end
          end
          S_HOLD: begin
            o_scl_o <= 1'b0;
            if (!hold_scl && dr_full_reg) begin
              sh_reg <= dr_reg;
              dr_full_reg <= 1'b0;
              bit_reg <= 4'h8;
              tra_bit <= 1'b1;
              st_reg <= S_BITS;
              ph_reg <= 2'h0;
            end else if (!hold_scl && cr_reg[`CR_STOP]) begin
              st_reg <= S_STOP;
              ph_reg <= 2'h0;
            end
          end
          S_BITS: begin
            if (ph_reg == 2'h0)
              o_sda_o <= sh_reg[7];
            else if (ph_reg == 2'h1)
              o_scl_o <= 1'b1;
            else if (ph_reg == 2'h2) begin
              // Lost when we drive high but the line reads low
              if (o_sda_o && !sda_s) begin
                arbitration_lost_flag <= 1'b1;
                master_slave_bit <= 1'b0;
                lost_now <= 1'b1;
                st_reg <= S_LOST;
              end
            end else begin
              o_scl_o <= 1'b0;
              sh_reg <= {sh_reg[6:0], 1'b0};
              bit_reg <= bit_reg - 4'h1;
              if (bit_reg == 4'h1)
                st_reg <= S_ACK;
            end
          end
          S_ACK: begin
            // Acknowledge bit is not arbitrated
            if (ph_reg == 2'h0)
              o_sda_o <= 1'b1;
            else if (ph_reg == 2'h1)
              o_scl_o <= 1'b1;
            else if (ph_reg == 2'h2) begin
              if (sda_s)
                ack_failure_flag <= 1'b1;
            end else begin
              o_scl_o <= 1'b0;
              st_reg <= S_HOLD;
              if (addr_phase_reg && hdr_pend_reg) begin
                hdr10_flag <= 1'b1;
                hdr_pend_reg <= 1'b0;
              end else
                byte_done_flag <= 1'b1;
            end
          end
          S_STOP: begin
            if (ph_reg == 2'h0)
              o_sda_o <= 1'b0;
            else if (ph_reg == 2'h1)
              o_scl_o <= 1'b1;
            else if (ph_reg == 2'h2) begin
              o_sda_o <= 1'b1;
              cr_reg[`CR_STOP] <= 1'b0;
              master_slave_bit <= 1'b0;
              addr_phase_reg <= 1'b0;
              st_reg <= S_IDLE;
            end
          end
          default: begin
            st_reg <= st_reg;
          end
        endcase
      end
      if (!master_slave_bit && st_reg != S_IDLE && !m_run) begin
        o_scl_o <= 1'b1;
        o_sda_o <= 1'b1;
        st_reg <= S_IDLE;
      end

      // Slave address capture of the first byte after a start
      if (!master_slave_bit && scl_rise && busy_bit) begin
        sh_reg <= {sh_reg[6:0], sda_s};
        bit_reg <= bit_reg + 4'h1;
      end
      if (start_det && !master_slave_bit)
        bit_reg <= 4'h0;
      if (!master_slave_bit && scl_fall && bit_reg == 4'h8 && !addr_phase_reg) begin
        addr_phase_reg <= 1'b1;
        if (gc_hit)
          general_call_seen_flag <= 1'b1;
        if ((addr_hit(sh_reg, oar1_reg) || gc_hit || h10_hit) && cr_reg[`CR_ACK])
          slv_ack_reg <= 1'b1;
      end
      // Match flag only after the acknowledge pulse, so the stretch follows it
      if (slv_ack_reg && scl_fall && bit_reg == 4'h9) begin
        slv_ack_reg <= 1'b0;
        addr_match_flag <= 1'b1;
      end

      // Disable clears control and status except the stop request
      if ((!block_on && !wr_cr) || (wr_cr && !i_wdata[`CR_ON])) begin
        cr_reg <= {2'h0, 1'b0, 3'h0, cr_reg[`CR_STOP], 1'b0};
        if (wr_cr)
          cr_reg <= {6'h00, cr_reg[`CR_STOP], 1'b0};
        start_sent_flag <= 1'b0;
        ack_failure_flag <= 1'b0;
        stop_seen_flag <= 1'b0;
        arbitration_lost_flag <= 1'b0;
        bus_error_flag <= 1'b0;
        general_call_seen_flag <= 1'b0;
        byte_done_flag <= 1'b0;
        addr_match_flag <= 1'b0;
        hdr10_flag <= 1'b0;
        master_slave_bit <= 1'b0;
        tra_bit <= 1'b0;
        busy_bit <= 1'b0;
        addr_phase_reg <= 1'b0;
        slv_ack_reg <= 1'b0;
        st_reg <= S_IDLE;
        o_scl_o <= 1'b1;
        o_sda_o <= 1'b1;
      end

      // Open-drain: enable only while pulling low; stretch on holding flags
      o_scl_oe <= drv_en && ((master_slave_bit && !o_scl_o) || hold_scl);
      o_sda_oe <= drv_en && ((master_slave_bit && !o_sda_o && !lost_now) || slv_ack_reg);
      o_irq <= interrupt_enable_bit && evf && block_on;
    end
  end
endmodule // i2c_status_address_clock

// >>> i2c_consts.vh
`ifndef I2C_CONSTS_VH
`define I2C_CONSTS_VH
`define A_CR      8'h64
`define A_SR1     8'h65
`define A_SR2     8'h66
`define A_CCR     8'h67
`define A_OAR1    8'h68
`define A_OAR2    8'h69
`define A_DR      8'h6A
`define OAR2_RST  8'h40
`define ZERO8     8'h00
`define CR_ON     5
`define CR_GC     4
`define CR_START  3
`define CR_ACK    2
`define CR_STOP   1
`define CR_ITE    0
`define GC_ADDR   7'h00
`define IGN_ADDR  8'h01
`define HDR10     5'h1E
`endif

// >>> i2c_sync3.v
module i2c_sync3 (
  input  wire i_mclk,
  input  wire i_rst_b,
  input  wire i_d,
  output reg  o_q
);
  reg [2:0] sh_reg;
  always @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sh_reg <= 3'h7;
      o_q    <= 1'b1;
    end else begin
      sh_reg <= {sh_reg[1:0], i_d};
      if (sh_reg[2] == sh_reg[1])
        o_q <= sh_reg[1];
    end
  end
endmodule // i2c_sync3

// >>> i2c_clkdiv.v
`include "i2c_consts.vh"
module i2c_clkdiv (
  input  wire       i_mclk,
  input  wire       i_rst_b,
  input  wire       i_run,
  input  wire       i_fast,
  input  wire [6:0] i_div,
  output reg        o_tick
);
  // Fast mode halves the quarter-period count
  reg  [8:0] cnt_reg;
  wire [8:0] lim = i_fast ? {2'h0, i_div} : {1'h0, i_div, 1'h0};
  always @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt_reg <= 9'h000;
      o_tick  <= 1'b0;
    end else if (!i_run) begin
      cnt_reg <= 9'h000;
      o_tick  <= 1'b0;
    end else if (cnt_reg >= lim) begin
      cnt_reg <= 9'h000;
      o_tick  <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 9'h001;
      o_tick  <= 1'b0;
    end
  end
endmodule // i2c_clkdiv

// >>> sac_assertions.sv
// ********
// Port-level checks
// ********
module sac_assertions (
  input wire logic       i_mclk,
  input wire logic       i_rst_b,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic       i_wr,
  input wire logic       i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic       i_scl,
  input wire logic       i_sda,
  input wire logic       o_scl_oe,
  input wire logic       o_scl_o,
  input wire logic       o_sda_oe,
  input wire logic       o_sda_o,
  input wire logic       o_irq
);
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_rst_b);
  logic       rd_q;
  logic [7:0] a_q;
  logic [7:0] ccr_sh;
  logic [7:0] oar1_sh;
  logic [1:0] oar2_sh;
  // Shadows follow every write: these fields keep their value across disable
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rd_q <= 1'b0;
      a_q <= 8'h00;
      ccr_sh <= 8'h00;
      oar1_sh <= 8'h00;
      oar2_sh <= 2'h0;
    end else begin
      rd_q <= i_rd;
      a_q <= i_addr;
      if (i_wr && i_addr == 8'h67) ccr_sh <= i_wdata;
      if (i_wr && i_addr == 8'h68) oar1_sh <= i_wdata;
      if (i_wr && i_addr == 8'h69) oar2_sh <= i_wdata[2:1];
    end
  end
  a_status_two_top: assert property (rd_q && a_q == 8'h66 |-> o_rdata[7:5] == 3'h0)
    else $error("status two top bits set");
  a_fast_bit_keeps: assert property (rd_q && a_q == 8'h67 |-> o_rdata[7] == ccr_sh[7])
    else $error("speed bit lost");
  a_divider_keeps: assert property (rd_q && a_q == 8'h67 |-> o_rdata[6:0] == ccr_sh[6:0])
    else $error("divider lost");
  a_own_low_keeps: assert property (rd_q && a_q == 8'h68 |-> o_rdata == oar1_sh)
    else $error("own id low lost");
  a_own_high_keeps: assert property (rd_q && a_q == 8'h69 |-> o_rdata[2:1] == oar2_sh)
    else $error("own id high lost");
  a_disable_release: assert property (i_wr && i_addr == 8'h64 && !i_wdata[5] |-> ##3 !(o_scl_oe || o_sda_oe || o_irq))
    else $error("outputs held after disable");
  a_disable_status: assert property (i_wr && i_addr == 8'h64 && !i_wdata[5] ##2 i_rd && (i_addr == 8'h65 || i_addr == 8'h66) |=> o_rdata == 8'h00)
    else $error("status kept after disable");
  a_errs_read_clear: assert property (i_rd && i_addr == 8'h66 ##1 i_rd && i_addr == 8'h66 |=> o_rdata[4:1] == 4'h0)
    else $error("error flags survive read");
  c_irq: cover property (o_irq);
  c_drive: cover property (o_scl_oe && o_sda_oe);
  c_stop: cover property (rd_q && a_q == 8'h66 && o_rdata[3]);
endmodule // sac_assertions

// >>> bus_peer.sv
// ********
// Other bus party, open drain with pull-ups
// ********
module bus_peer #(
  parameter int HALF = 20
) (
  input  wire logic i_mclk,
  input  wire logic i_dut_scl_oe,
  input  wire logic i_dut_sda_oe,
  output logic      o_scl,
  output logic      o_sda
);
  timeunit 1ns;
  timeprecision 100ps;
  logic scl_low = 1'b0;
  logic sda_low = 1'b0;
  assign o_scl = !(i_dut_scl_oe | scl_low);
  assign o_sda = !(i_dut_sda_oe | sda_low);
  task automatic idle(input int n);
    repeat (n) @(posedge i_mclk);
  endtask
  // The device may stretch the clock; a bound keeps a stuck line from hanging
  task automatic wait_scl(input logic lvl);
    int k;
    k = 0;
    while (o_scl !== lvl && k < 2000) begin
      @(posedge i_mclk);
      k++;
    end
    if (o_scl !== lvl) begin
      tb.failures++;
      $display("CHECK FAILED t=%0t clock line stuck", $time);
      tb.summarize();
    end
  endtask
  task automatic pulse(output logic s);
    scl_low <= 1'b0;
    wait_scl(1'b1);
    idle(HALF);
    s = o_sda;
    scl_low <= 1'b1;
    idle(HALF);
  endtask
  task automatic gen_start();
    sda_low <= 1'b1;
    idle(HALF);
    scl_low <= 1'b1;
    idle(HALF);
  endtask
  task automatic gen_stop();
    sda_low <= 1'b1;
    idle(4);
    scl_low <= 1'b0;
    wait_scl(1'b1);
    idle(HALF);
    sda_low <= 1'b0;
    idle(HALF);
  endtask
  task automatic send_bits(input logic [7:0] d, input int n, output logic ack);
    logic s;
    s = 1'b1;
    for (int i = 0; i < n; i++) begin
      sda_low <= !d[7-i];
      idle(4);
      pulse(s);
    end
    if (n == 8) begin
      sda_low <= 1'b0;
      idle(4);
      pulse(s);
    end
    ack = !s;
  endtask
  // Listens as a silent slave: the acknowledge slot is left high
  task automatic recv_byte(output logic [7:0] d);
    for (int i = 7; i >= 0; i--) begin
      wait_scl(1'b0);
      wait_scl(1'b1);
      d[i] = o_sda;
    end
  endtask
endmodule // bus_peer

// >>> tb.sv
// ********
// Testbench
// ********
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic       i_mclk = 1'b0;
  logic       i_rst_b = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [7:0] i_wdata = 8'h00;
  logic       i_wr = 1'b0;
  logic       i_rd = 1'b0;
  logic [7:0] o_rdata;
  logic       o_scl_oe, o_scl_o, o_sda_oe, o_sda_o, o_irq;
  wire        scl, sda;
  int         failures = 0;
  int         checks = 0;
  logic [7:0] v;
  logic       ack;
  always #5 i_mclk = ~i_mclk;
  i2c_status_address_clock i2c_status_address_clock_i (
    .i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_scl(scl), .i_sda(sda),
    .o_scl_oe(o_scl_oe), .o_scl_o(o_scl_o), .o_sda_oe(o_sda_oe),
    .o_sda_o(o_sda_o), .o_irq(o_irq));
  bus_peer bus_peer_i (.i_mclk(i_mclk), .i_dut_scl_oe(o_scl_oe),
    .i_dut_sda_oe(o_sda_oe), .o_scl(scl), .o_sda(sda));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_mclk);
    i_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1;
    d = o_rdata;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    chk(d, e);
  endtask
  task automatic wait_irq();
    int k;
    k = 0;
    while (o_irq !== 1'b1 && k < 500) begin
      idle(1);
      k++;
    end
    chk({7'h00, o_irq}, 8'h01);
  endtask
  task automatic t_regs();
    logic [7:0] rv [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h40, 8'h00, 8'h00};
    for (int i = 0; i < 9; i++) rdc(8'(8'h63 + i), rv[i]);
    wr(8'h67, 8'h84);
    wr(8'h68, 8'hA4);
    wr(8'h69, 8'h46);
    wr(8'h64, 8'h20);
    wr(8'h69, 8'h86);
    rdc(8'h69, 8'h46);
    wr(8'h64, 8'h00);
    rdc(8'h67, 8'h84);
    rdc(8'h68, 8'hA4);
    rdc(8'h69, 8'h46);
  endtask
  task automatic t_slave();
    logic [7:0] a [4] = '{8'hA4, 8'hA5, 8'hA6, 8'h01};
    logic [7:0] e [4] = '{8'h01, 8'h01, 8'h00, 8'h00};
    wr(8'h64, 8'h20);
    wr(8'h64, 8'h34);
    for (int i = 0; i < 4; i++) begin
      bus_peer_i.gen_start();
      bus_peer_i.send_bits(a[i], 8, ack);
      chk({7'h00, ack}, e[i]);
      rd(8'h66, v);
      chk(v & 8'h01, 8'h00);
      rd(8'h65, v);
      bus_peer_i.gen_stop();
      rd(8'h66, v);
    end
    bus_peer_i.gen_start();
    bus_peer_i.send_bits(8'h00, 8, ack);
    chk({7'h00, ack}, 8'h01);
    rdc(8'h66, 8'h01);
    rd(8'h65, v);
    bus_peer_i.gen_stop();
    rdc(8'h66, 8'h08);
    rdc(8'h66, 8'h00);
  endtask
  task automatic t_bus_error_flag();
    wr(8'h64, 8'h35);
    bus_peer_i.gen_start();
    bus_peer_i.send_bits(8'hFF, 3, ack);
    bus_peer_i.gen_stop();
    wait_irq();
    rdc(8'h66, 8'h02);
    idle(2);
    chk({7'h00, o_irq}, 8'h00);
  endtask
  task automatic t_master();
    int k;
    wr(8'h64, 8'h29);
    k = 0;
    v = 8'h00;
    while (v[0] !== 1'b1 && k < 200) begin
      rd(8'h65, v);
      k++;
    end
    chk(v & 8'h03, 8'h03);
    // Status-one read above comes first, so this write must clear the start flag
    wr(8'h6A, 8'hA4);
    bus_peer_i.recv_byte(v);
    chk(v, 8'hA4);
    rd(8'h65, v);
    chk(v & 8'h01, 8'h00);
    wait_irq();
    rdc(8'h66, 8'h10);
    rdc(8'h66, 8'h00);
    wr(8'h64, 8'h00);
    idle(1);
    rdc(8'h65, 8'h00);
    rdc(8'h64, 8'h00);
    chk({5'h00, o_scl_oe, o_sda_oe, o_irq}, 8'h00);
  endtask
  task automatic summarize();
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge i_mclk);
    i_rst_b <= 1'b1;
    idle(3);
    t_regs();
    t_slave();
    t_bus_error_flag();
    t_master();
    summarize();
  end
endmodule // tb
bind i2c_status_address_clock sac_assertions sac_assertions_i (
  .i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
  .i_rd(i_rd), .o_rdata(o_rdata), .i_scl(i_scl), .i_sda(i_sda), .o_scl_oe(o_scl_oe),
  .o_scl_o(o_scl_o), .o_sda_oe(o_sda_oe), .o_sda_o(o_sda_o), .o_irq(o_irq));
